/* File: rfcd_top.sv */
`timescale 1ns/100ps
`include "rfcd_defs.svh"
module rfcd_top
  import rfcd_pkg::*;
#(
  parameter int MAX_PAYLOAD = `RFCD_MAX_PAYLOAD,
  parameter int ACK_SLOTS   = `RFCD_ACK_SLOTS,
  localparam int PB         = $clog2(MAX_PAYLOAD),
  localparam int CW         = PB + 1,
  localparam int SW         = $clog2(ACK_SLOTS)
) (
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_sclk,
  input  wire logic          i_cs_n,
  input  wire logic          i_mosi,
  output logic               o_miso,
  output logic               o_miso_oe,
  input  wire logic          i_rx_mode,
  input  wire logic [7:0]    i_status,
  input  wire logic [CW-1:0] i_rx_width,
  input  wire logic [7:0]    i_rx_data,
  input  wire logic          i_rx_empty,
  output logic               o_rx_take,
  output logic               o_rx_release,
  output logic               o_rx_flush,
  output logic               o_txw_valid,
  output logic [7:0]         o_txw_data,
  output logic               o_txw_no_reply,
  output logic               o_txw_end,
  output logic               o_tx_flush,
  output logic               o_repeat_last,
  input  wire logic          i_ack_req,
  input  wire logic [2:0]    i_ack_pipe,
  output logic               o_ack_valid,
  output logic [7:0]         o_ack_data,
  output logic               o_ack_last,
  output logic               o_ack_none,
  output logic [2:0]         o_ack_pending
);
  localparam logic [CW-1:0] CNT_MAX = CW'(MAX_PAYLOAD);

  if (ACK_SLOTS < 2 || ACK_SLOTS > 4) begin : g_bad_slots
    $error("ACK_SLOTS must be 2 to 4");
  end
  if (MAX_PAYLOAD < 2 || MAX_PAYLOAD > 32 || (MAX_PAYLOAD & (MAX_PAYLOAD - 1)) != 0) begin : g_bad_len
    $error("MAX_PAYLOAD must be a power of two from 2 to 32");
  end

  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= `RFCD_RST_SYNC;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // link side: mosi sampled on falling, miso driven on rising edge
  logic       lrst_n;
  logic [2:0] rbit, next_rbit;
  logic [6:0] rsh, next_rsh;
  logic [7:0] rx_byte, next_rx_byte;
  logic       rx_tgl, next_rx_tgl;
  logic [2:0] tbit, next_tbit;
  logic [6:0] tsh, next_tsh;
  logic       next_miso;
  logic [7:0] tx_word, next_word;
  assign lrst_n = rst_n & ~i_cs_n;

  always_comb begin
    next_rbit    = rbit + 3'h1;
    next_rsh     = {rsh[5:0], i_mosi};
    next_rx_byte = rx_byte;
    next_rx_tgl  = rx_tgl;
    if (rbit == 3'h7) begin
      next_rx_byte = {rsh, i_mosi};
      next_rx_tgl  = ~rx_tgl;
    end
    next_tbit = tbit + 3'h1;
    {next_miso, next_tsh} = (tbit == 3'h0) ? tx_word : {tsh, 1'b0};
  end

  always_ff @(negedge i_sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      rbit <= 3'h0;
      rsh  <= 7'h00;
    end else begin
      rbit <= next_rbit;
      rsh  <= next_rsh;
    end
  end

  // byte and toggle survive select so the crossing sees no false edge
  always_ff @(negedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= 8'h00;
      rx_tgl  <= 1'b0;
    end else begin
      rx_byte <= next_rx_byte;
      rx_tgl  <= next_rx_tgl;
    end
  end

  always_ff @(posedge i_sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      tbit      <= 3'h0;
      tsh       <= 7'h00;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      tbit      <= next_tbit;
      tsh       <= next_tsh;
      o_miso    <= next_miso;
      o_miso_oe <= 1'b1;
    end
  end

  // crossing: select level and byte toggle, three flops each
  logic [1:0] cs_sync;
  logic       cs_prev;
  logic [2:0] tg_sync;
  logic       frame_start, frame_end, byte_in;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync <= `RFCD_CS_IDLE;
      cs_prev <= 1'b1;
      tg_sync <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[0], i_cs_n};
      cs_prev <= cs_sync[1];
      tg_sync <= {tg_sync[1:0], rx_tgl};
    end
  end
  assign frame_start = cs_prev & ~cs_sync[1];
  assign frame_end   = ~cs_prev & cs_sync[1];
  // rx_byte is held until the next byte, so it is stable when read here
  assign byte_in     = tg_sync[2] ^ tg_sync[1];

  rfcd_frame_t         st, next_st;
  rfcd_cmd_t           cmd, next_cmd;
  logic [CW-1:0]       cnt, next_cnt;
  logic [SW-1:0]       wslot, next_wslot;
  logic [2:0]          ack_pipe_sel, next_ack_pipe_sel;
  logic                next_txw_valid, next_txw_no_reply, next_txw_end, next_tx_flush;
  logic [7:0]          next_txw_data;
  logic                next_rx_flush, next_rx_take, next_rx_release, next_repeat;
  logic                free_found;
  logic [SW-1:0]       free_idx;
  logic                mem_we;
  logic [SW+PB-1:0]    mem_waddr, mem_raddr;
  logic                ack_commit;
  logic                slot_valid [ACK_SLOTS];

  always_comb begin
    free_found = 1'b0;
    free_idx   = '0;
    for (int i = ACK_SLOTS - 1; i >= 0; i--) begin
      if (!slot_valid[i]) begin
        free_found = 1'b1;
        free_idx   = SW'(i);
      end
    end
  end

  always_comb begin
    next_st           = st;
    next_cmd          = cmd;
    next_cnt          = cnt;
    next_wslot        = wslot;
    next_ack_pipe_sel = ack_pipe_sel;
    next_word         = `RFCD_FILL_BYTE;
    next_txw_valid    = 1'b0;
    next_txw_data     = o_txw_data;
    next_txw_no_reply = o_txw_no_reply;
    next_txw_end      = 1'b0;
    next_tx_flush     = 1'b0;
    next_rx_flush     = 1'b0;
    next_rx_take      = 1'b0;
    next_rx_release   = 1'b0;
    next_repeat       = o_repeat_last;
    unique case (st)
      ST_IDLE: begin
        next_word = i_status;
        if (frame_start) begin
          next_st  = ST_CMD;
          next_cnt = '0;
        end
      end
      ST_CMD: begin
        next_word = i_status;
        if (byte_in) begin
          next_cmd          = rfcd_decode(rx_byte, i_rx_mode);
          next_ack_pipe_sel = rx_byte[2:0];
          next_wslot        = free_idx;
          next_st           = ST_DATA;
          // no free reply slot refuses the load
          if (next_cmd == CMD_LOAD_ACK && !free_found) next_cmd = CMD_DROP;
          if (next_cmd == CMD_LOAD_TX) next_repeat = 1'b0;
        end
      end
      ST_DATA: begin
        // width byte, zero when queue empty
        if (cmd == CMD_RD_WIDTH && cnt == '0 && !i_rx_empty) next_word = 8'(i_rx_width);
        // head payload byte follows the read pointer
        if (cmd == CMD_RD_RX && !i_rx_empty) next_word = i_rx_data;
        if (byte_in) begin
          if (cnt < CNT_MAX) next_cnt = cnt + CW'(1);
          // bytes stream out in arrival order, byte 0 first
          if ((cmd == CMD_LOAD_TX || cmd == CMD_NOREPLY) && cnt < CNT_MAX) begin
            next_txw_valid    = 1'b1;
            next_txw_data     = rx_byte;
            next_txw_no_reply = (cmd == CMD_NOREPLY);
          end
          if (cmd == CMD_RD_RX && !i_rx_empty && cnt < i_rx_width) next_rx_take = 1'b1;
        end
      end
    endcase
    if (frame_end && st != ST_IDLE) begin
      next_st = ST_IDLE;
      if (st == ST_DATA) begin
        if (cmd == CMD_FLUSH_TX) begin
          next_tx_flush = 1'b1;
          next_repeat   = 1'b0;
        end
        if (cmd == CMD_FLUSH_RX) next_rx_flush = 1'b1;
        if (cmd == CMD_REPEAT) next_repeat = 1'b1;
        if ((cmd == CMD_LOAD_TX || cmd == CMD_NOREPLY) && cnt != '0) next_txw_end = 1'b1;
        if (cmd == CMD_RD_RX && cnt != '0 && !i_rx_empty) next_rx_release = 1'b1;
      end
    end
  end

  // reply bytes land in the slot from byte 0
  assign mem_we     = byte_in && st == ST_DATA && cmd == CMD_LOAD_ACK && cnt < CNT_MAX;
  assign mem_waddr  = {wslot, cnt[PB-1:0]};
  assign ack_commit = frame_end && st == ST_DATA && cmd == CMD_LOAD_ACK && cnt != '0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st             <= ST_IDLE;
      cmd            <= CMD_DROP;
      cnt            <= '0;
      wslot          <= '0;
      ack_pipe_sel   <= 3'h0;
      tx_word        <= `RFCD_FILL_BYTE;
      o_txw_valid    <= 1'b0;
      o_txw_data     <= 8'h00;
      o_txw_no_reply <= 1'b0;
      o_txw_end      <= 1'b0;
      o_tx_flush     <= 1'b0;
      o_rx_flush     <= 1'b0;
      o_rx_take      <= 1'b0;
      o_rx_release   <= 1'b0;
      o_repeat_last  <= 1'b0;
    end else begin
      st             <= next_st;
      cmd            <= next_cmd;
      cnt            <= next_cnt;
      wslot          <= next_wslot;
      ack_pipe_sel   <= next_ack_pipe_sel;
      tx_word        <= next_word;
      o_txw_valid    <= next_txw_valid;
      o_txw_data     <= next_txw_data;
      o_txw_no_reply <= next_txw_no_reply;
      o_txw_end      <= next_txw_end;
      o_tx_flush     <= next_tx_flush;
      o_rx_flush     <= next_rx_flush;
      o_rx_take      <= next_rx_take;
      o_rx_release   <= next_rx_release;
      o_repeat_last  <= next_repeat;
    end
  end

  // reply slots, ranked by age
  rfcd_ack_st_t  as_st, next_as_st;
  logic [SW-1:0] as_slot, next_as_slot, pick;
  logic [CW-1:0] as_idx, next_as_idx;
  logic          next_valid [ACK_SLOTS];
  logic [2:0]    slot_pipe [ACK_SLOTS], next_pipe [ACK_SLOTS];
  logic [CW-1:0] slot_len [ACK_SLOTS], next_len [ACK_SLOTS];
  logic [1:0]    slot_rank [ACK_SLOTS], next_rank [ACK_SLOTS];
  logic          found, free_now, next_ack_valid, next_ack_last, next_ack_none;
  logic [1:0]    live;
  logic [2:0]    next_pending;

  always_comb begin
    next_valid     = slot_valid;
    next_pipe      = slot_pipe;
    next_len       = slot_len;
    next_rank      = slot_rank;
    next_as_st     = as_st;
    next_as_slot   = as_slot;
    next_as_idx    = as_idx;
    next_ack_valid = 1'b0;
    next_ack_last  = 1'b0;
    next_ack_none  = 1'b0;
    free_now       = 1'b0;
    found          = 1'b0;
    pick           = '0;
    live           = 2'h0;
    next_pending   = 3'h0;
    // oldest pending slot of the asked pipe
    for (int i = 0; i < ACK_SLOTS; i++) begin
      if (slot_valid[i] && slot_pipe[i] == i_ack_pipe && (!found || slot_rank[i] < slot_rank[pick])) begin
        found = 1'b1;
        pick  = SW'(i);
      end
    end
    unique case (as_st)
      AS_IDLE: begin
        if (i_ack_req && found) begin
          next_as_st   = AS_RUN;
          next_as_slot = pick;
          next_as_idx  = '0;
        end
        if (i_ack_req && !found) next_ack_none = 1'b1;
      end
      AS_RUN: begin
        next_ack_valid = 1'b1;
        next_ack_last  = (as_idx == slot_len[as_slot] - CW'(1));
        next_as_idx    = as_idx + CW'(1);
        if (next_ack_last) begin
          next_as_st = AS_IDLE;
          free_now   = 1'b1;
        end
      end
    endcase
    if (free_now) begin
      next_valid[as_slot] = 1'b0;
      for (int i = 0; i < ACK_SLOTS; i++) begin
        if (slot_valid[i] && slot_rank[i] > slot_rank[as_slot]) next_rank[i] = slot_rank[i] - 2'h1;
      end
    end
    for (int i = 0; i < ACK_SLOTS; i++) begin
      if (next_valid[i]) live = live + 2'h1;
    end
    // commit the loaded reply, youngest rank
    if (ack_commit) begin
      next_valid[wslot] = 1'b1;
      next_pipe[wslot]  = ack_pipe_sel;
      next_len[wslot]   = cnt;
      next_rank[wslot]  = live;
    end
    for (int i = 0; i < ACK_SLOTS; i++) begin
      if (next_valid[i]) next_pending = next_pending + 3'h1;
    end
  end
  assign mem_raddr = {as_slot, as_idx[PB-1:0]};

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      as_st         <= AS_IDLE;
      as_slot       <= '0;
      as_idx        <= '0;
      o_ack_valid   <= 1'b0;
      o_ack_last    <= 1'b0;
      o_ack_none    <= 1'b0;
      o_ack_pending <= 3'h0;
      for (int i = 0; i < ACK_SLOTS; i++) begin
        slot_valid[i] <= 1'b0;
        slot_pipe[i]  <= 3'h0;
        slot_len[i]   <= '0;
        slot_rank[i]  <= 2'h0;
      end
    end else begin
      as_st         <= next_as_st;
      as_slot       <= next_as_slot;
      as_idx        <= next_as_idx;
      o_ack_valid   <= next_ack_valid;
      o_ack_last    <= next_ack_last;
      o_ack_none    <= next_ack_none;
      o_ack_pending <= next_pending;
      slot_valid    <= next_valid;
      slot_pipe     <= next_pipe;
      slot_len      <= next_len;
      slot_rank     <= next_rank;
    end
  end

  rfcd_mem #(
    .WIDTH (8),
    .DEPTH ((1 << SW) * MAX_PAYLOAD)
  ) u_ack_mem (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (rx_byte),
    .i_raddr (mem_raddr),
    .o_rdata (o_ack_data)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);
  logic data_byte, closing, older_wait;
  assign data_byte = byte_in && st == ST_DATA;
  assign closing   = frame_end && st == ST_DATA;
  always_comb begin
    older_wait = 1'b0;
    for (int i = 0; i < ACK_SLOTS; i++) begin
      if (slot_valid[i] && slot_pipe[i] == slot_pipe[as_slot] && slot_rank[i] < slot_rank[as_slot]) older_wait = 1'b1;
    end
  end

  property p_load_tx;
    data_byte && cmd == CMD_LOAD_TX && cnt < CNT_MAX |=> o_txw_valid && !o_txw_no_reply && o_txw_data == $past(rx_byte);
  endproperty
  a_load_tx: assert property (p_load_tx) else $error("transmit byte not forwarded");
  property p_flush_tx;
    closing && cmd == CMD_FLUSH_TX |=> o_tx_flush && !o_repeat_last ##1 !o_tx_flush;
  endproperty
  a_flush_tx: assert property (p_flush_tx) else $error("transmit clear missing");
  property p_flush_rx;
    closing && cmd == CMD_FLUSH_RX |=> o_rx_flush ##1 !o_rx_flush;
  endproperty
  a_flush_rx: assert property (p_flush_rx) else $error("receive clear missing");
  property p_repeat_on;
    closing && cmd == CMD_REPEAT |=> o_repeat_last;
  endproperty
  a_repeat_on: assert property (p_repeat_on) else $error("repeat not enabled");
  property p_repeat_hold;
    $fell(o_repeat_last) |-> $past(cmd) == CMD_LOAD_TX || $past(cmd) == CMD_FLUSH_TX || $past(next_cmd) == CMD_LOAD_TX;
  endproperty
  a_repeat_hold: assert property (p_repeat_hold) else $error("repeat dropped without cause");
  property p_width;
    st == ST_DATA && cmd == CMD_RD_WIDTH && cnt == '0 && !i_rx_empty |=> tx_word == 8'($past(i_rx_width));
  endproperty
  a_width: assert property (p_width) else $error("width byte wrong");
  property p_ack_pipe;
    ack_commit |=> slot_valid[$past(wslot)] && slot_pipe[$past(wslot)] == $past(ack_pipe_sel);
  endproperty
  a_ack_pipe: assert property (p_ack_pipe) else $error("reply pipe not stored");
  property p_ack_full;
    st == ST_CMD && byte_in && rfcd_decode(rx_byte, i_rx_mode) == CMD_LOAD_ACK && !free_found |=> cmd == CMD_DROP;
  endproperty
  a_ack_full: assert property (p_ack_full) else $error("reply load taken while full");
  property p_ack_order;
    as_st == AS_RUN |-> !older_wait;
  endproperty
  a_ack_order: assert property (p_ack_order) else $error("younger reply sent first");
  property p_ack_len;
    ack_commit |=> slot_len[$past(wslot)] == $past(cnt) && o_ack_pending <= 3'(ACK_SLOTS);
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("reply length wrong");
  property p_noreply;
    data_byte && cmd == CMD_NOREPLY && cnt < CNT_MAX |=> o_txw_valid && o_txw_no_reply;
  endproperty
  a_noreply: assert property (p_noreply) else $error("no-reply flag missing");
  property p_nop;
    closing && cmd == CMD_NOP |=> !o_tx_flush && !o_rx_flush && !o_txw_end && $stable(o_repeat_last);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op had an effect");
  property p_release;
    closing && cmd == CMD_RD_RX && cnt != '0 && !i_rx_empty |=> o_rx_release ##1 !o_rx_release;
  endproperty
  a_release: assert property (p_release) else $error("read payload not removed");
  property p_frame;
    st == ST_CMD && byte_in && !frame_end |=> st == ST_DATA;
  endproperty
  a_frame: assert property (p_frame) else $error("command byte not taken");
  c_full_load: cover property (closing && cmd == CMD_LOAD_TX && cnt == CNT_MAX);
  c_ack_sent: cover property (o_ack_valid && o_ack_last);
  c_rx_read: cover property (closing && cmd == CMD_RD_RX && cnt != '0);
  c_ack_full: cover property (st == ST_CMD && byte_in && !free_found);
endmodule

/* File: rfcd_defs.svh */
`ifndef RFCD_DEFS_SVH
`define RFCD_DEFS_SVH

`define RFCD_CMD_LOAD_TX     8'hA0
`define RFCD_CMD_FLUSH_TX    8'hE1
`define RFCD_CMD_FLUSH_RX    8'hE2
`define RFCD_CMD_REPEAT      8'hE3
`define RFCD_CMD_RD_WIDTH    8'h60
`define RFCD_CMD_RD_RX       8'h61
`define RFCD_CMD_ACK_BASE    8'hA8
`define RFCD_CMD_ACK_MASK    8'hF8
`define RFCD_CMD_NOREPLY     8'hB0
`define RFCD_CMD_NOP         8'hFF
`define RFCD_PIPE_MAX        3'h5
`define RFCD_MAX_PAYLOAD     32
`define RFCD_ACK_SLOTS       3
`define RFCD_FILL_BYTE       8'h00
`define RFCD_RST_SYNC        2'h0
`define RFCD_CS_IDLE         2'h3
`endif

/* File: rfcd_pkg.sv */
package rfcd_pkg;
`include "rfcd_defs.svh"

  typedef enum logic [3:0] {
    CMD_DROP, CMD_LOAD_TX, CMD_NOREPLY, CMD_FLUSH_TX, CMD_FLUSH_RX,
    CMD_REPEAT, CMD_RD_WIDTH, CMD_RD_RX, CMD_LOAD_ACK, CMD_NOP
  } rfcd_cmd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} rfcd_frame_t;

  typedef enum logic {AS_IDLE, AS_RUN} rfcd_ack_st_t;

  // decode, mode-gated except width read, payload read and no-op; wrong mode or unknown code gives CMD_DROP
  function automatic rfcd_cmd_t rfcd_decode(input logic [7:0] code, input logic rx_mode);
    rfcd_cmd_t c;
    c = CMD_DROP;
    if (code == `RFCD_CMD_LOAD_TX && !rx_mode) c = CMD_LOAD_TX;
    if (code == `RFCD_CMD_NOREPLY && !rx_mode) c = CMD_NOREPLY;
    if (code == `RFCD_CMD_FLUSH_TX && !rx_mode) c = CMD_FLUSH_TX;
    if (code == `RFCD_CMD_REPEAT && !rx_mode) c = CMD_REPEAT;
    if (code == `RFCD_CMD_FLUSH_RX && rx_mode) c = CMD_FLUSH_RX;
    if (code == `RFCD_CMD_RD_WIDTH) c = CMD_RD_WIDTH;
    if (code == `RFCD_CMD_RD_RX) c = CMD_RD_RX;
    if (code == `RFCD_CMD_NOP) c = CMD_NOP;
    if ((code & `RFCD_CMD_ACK_MASK) == `RFCD_CMD_ACK_BASE && rx_mode && code[2:0] <= `RFCD_PIPE_MAX) c = CMD_LOAD_ACK;
    return c;
  endfunction
endpackage

/* File: rfcd_mem.sv */
`timescale 1ns/100ps
module rfcd_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [WIDTH-1:0]         o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("rfcd_mem needs DEPTH >= 2 and WIDTH >= 1");
  end

  // storage carries no reset so it can map onto ram cells
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

/* File: rfcd_host_model.sv */
`timescale 1ns/100ps
module rfcd_host_model (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end
  // select falls before the command byte
  task automatic open_frame();
    @(posedge i_clk);
    #1 o_cs_n = 1'b0;
    repeat (5) @(posedge i_clk);
  endtask
  // mode 1: change on rising, sample on falling; clock still between bytes
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge i_clk);
    #1;
    for (int i = 7; i >= 0; i--) begin
      #3 o_sclk = 1'b1;
      o_mosi = tx[i];
      #3 o_sclk = 1'b0;
      rx[i] = i_miso;
    end
    // spacing lets the word cross into the system domain
    repeat (10) @(posedge i_clk);
    #1 o_mosi = ~o_mosi;
  endtask
  task automatic close_frame();
    @(posedge i_clk);
    #1 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

/* File: radio_fifo_command_decoder_bench.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; $display("Error %s: expected %0h, seen %0h", n, e, a); end end
module radio_fifo_command_decoder_bench;
  logic       i_clk = 0, i_arst_n = 0, rx_mode = 0, rx_empty = 0, ack_req = 0;
  logic       sclk, cs_n, mosi, miso, miso_oe, miso_w;
  logic [7:0] status = 8'h5A, rx_data = 8'hC3, txw_data, ack_data, r0, r1;
  logic [5:0] rx_width = 6'h07;
  logic [2:0] ack_pipe = 3'h0, pend;
  logic       take, rel, rxf, txv, nrp, txe, txf, rep, av, al, an, nr;
  logic [7:0] txq[$];
  int         errors = 0, total_checks = 0, n_te = 0, n_txf = 0, n_rxf = 0, n_rel = 0, n_tk = 0;
  int         n_al = 0, n_av = 0;
  always #20 i_clk = ~i_clk;
  assign miso_w = miso_oe ? miso : 1'bz;
  rfcd_top rfcd_top_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe), .i_rx_mode(rx_mode), .i_status(status), .i_rx_width(rx_width),
    .i_rx_data(rx_data), .i_rx_empty(rx_empty), .o_rx_take(take), .o_rx_release(rel), .o_rx_flush(rxf),
    .o_txw_valid(txv), .o_txw_data(txw_data), .o_txw_no_reply(nrp), .o_txw_end(txe), .o_tx_flush(txf),
    .o_repeat_last(rep), .i_ack_req(ack_req), .i_ack_pipe(ack_pipe), .o_ack_valid(av), .o_ack_data(ack_data),
    .o_ack_last(al), .o_ack_none(an), .o_ack_pending(pend));
  rfcd_host_model rfcd_host_model_i (.i_clk(i_clk), .i_miso(miso_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  always @(posedge i_clk) begin
    if (txv === 1'b1) begin
      txq.push_back(txw_data);
      nr = nrp;
    end
    n_te += int'(txe === 1'b1);
    n_txf += int'(txf === 1'b1);
    n_rxf += int'(rxf === 1'b1);
    n_rel += int'(rel === 1'b1);
    n_tk += int'(take === 1'b1);
    n_av += int'(av === 1'b1);
    n_al += int'(al === 1'b1);
  end
  task automatic wrap_up();
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] c, input logic [7:0] d, input int n);
    logic [7:0] t;
    rfcd_host_model_i.open_frame();
    rfcd_host_model_i.xbyte(c, r0);
    r1 = 8'h00;
    for (int i = 0; i < n; i++) begin
      rfcd_host_model_i.xbyte(d + 8'(i), t);
      if (i == 0) r1 = t;
    end
    rfcd_host_model_i.close_frame();
  endtask
  // asks the reply engine once; bursts are never overlapped
  task automatic ask(input logic [2:0] p, input logic [7:0] ed, input logic en);
    int k;
    @(posedge i_clk);
    #1 ack_req = 1'b1;
    ack_pipe = p;
    @(posedge i_clk);
    #1 ack_req = 1'b0;
    for (k = 0; k < 10 && av !== 1'b1 && an !== 1'b1; k++) @(posedge i_clk) #1;
    if (k == 10) begin
      errors++;
      wrap_up();
    end
    `CHK("ack none", en, an)
    if (!en) `CHK("ack byte", ed, ack_data)
    for (k = 0; k < 40 && av === 1'b1; k++) @(posedge i_clk) #1;
  endtask
  task automatic s_tx();
    frame(8'hFF, 8'h00, 0);
    `CHK("status", 8'h5A, r0)
    `CHK("nop quiet", 0, txq.size() + n_txf)
    frame(8'hA0, 8'h10, 2);
    `CHK("load count", 2, txq.size())
    `CHK("load first", 8'h10, txq[0])
    `CHK("load end", 1, n_te)
    frame(8'hE3, 8'h00, 0);
    `CHK("repeat on", 1'b1, rep)
    frame(8'hB0, 8'h20, 1);
    `CHK("no reply", 1'b1, nr)
    frame(8'hA0, 8'h30, 1);
    `CHK("repeat off load", 1'b0, rep)
    frame(8'hE3, 8'h00, 0);
    frame(8'hE1, 8'h00, 0);
    `CHK("tx flush", 1, n_txf)
    `CHK("repeat off flush", 1'b0, rep)
    frame(8'hE2, 8'h00, 0);
    `CHK("rx flush tx mode", 0, n_rxf)
    frame(8'hA0, 8'h80, 33);
    `CHK("load limit", 36, txq.size())
  endtask
  task automatic s_rx();
    #1 rx_mode = 1'b1;
    frame(8'hE1, 8'h00, 0);
    `CHK("tx flush rx mode", 1, n_txf)
    frame(8'hE2, 8'h00, 0);
    `CHK("rx flush", 1, n_rxf)
    frame(8'h60, 8'h00, 1);
    `CHK("width", 8'h07, r1)
    frame(8'h61, 8'h00, 2);
    `CHK("read byte", 8'hC3, r1)
    `CHK("takes", 2, n_tk)
    `CHK("release", 1, n_rel)
    #1 rx_empty = 1'b1;
    frame(8'h60, 8'h00, 1);
    `CHK("width empty", 8'h00, r1)
    frame(8'h61, 8'h00, 1);
    `CHK("empty byte", 8'h00, r1)
    `CHK("empty no take", 2, n_tk)
    `CHK("empty kept", 1, n_rel)
  endtask
  task automatic s_ack();
    frame(8'hA9, 8'h40, 2);
    frame(8'hA9, 8'h50, 1);
    frame(8'hAA, 8'h60, 1);
    `CHK("pending full", 3'h3, pend)
    frame(8'hAB, 8'h70, 1);
    `CHK("fourth refused", 3'h3, pend)
    ask(3'h1, 8'h40, 1'b0);
    `CHK("slot freed", 3'h2, pend)
    frame(8'hAE, 8'h77, 1);
    `CHK("pipe six refused", 3'h2, pend)
    ask(3'h3, 8'h00, 1'b1);
    ask(3'h1, 8'h50, 1'b0);
    ask(3'h2, 8'h60, 1'b0);
    `CHK("all sent", 3'h0, pend)
    `CHK("reply bytes", 4, n_av)
    `CHK("last marks", 3, n_al)
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    repeat (6) @(posedge i_clk);
    s_tx();
    s_rx();
    s_ack();
    wrap_up();
  end
endmodule
